/* File: hw/cbr_pkg.sv */
package cbr_pkg;
   // ==================================================
   // sizes
   localparam int CBR_CHAN_CNT = 3;
   localparam int CBR_DATA_W = 24;
   localparam int CBR_REG_W = 16;
   localparam int CBR_ADDR_W = 6;

   // ==================================================
   // register offsets
   localparam logic [5:0] CBR_OFS_IDENT = 6'h00;
   localparam logic [5:0] CBR_OFS_STATUS = 6'h01;
   localparam logic [5:0] CBR_OFS_MODE = 6'h02;
   localparam logic [5:0] CBR_OFS_CLOCK = 6'h03;
   localparam logic [5:0] CBR_OFS_GAIN = 6'h04;
   localparam logic [5:0] CBR_OFS_CFG = 6'h06;
   localparam logic [5:0] CBR_OFS_CHANNEL0_PHASE_INPUT_CONFIG = 6'h09;
   localparam logic [5:0] CBR_OFS_CH0_OCAL_HI = 6'h0A;
   localparam logic [5:0] CBR_OFS_CH0_OCAL_LO = 6'h0B;

   // ==================================================
   // reset values
   localparam logic [15:0] CBR_RST_STATUS = 16'h0540;
   localparam logic [15:0] CBR_RST_MODE = 16'h0510;
   localparam logic [15:0] CBR_RST_CLOCK = 16'h070E;
   localparam logic [15:0] CBR_RST_GAIN = 16'h0000;
   localparam logic [15:0] CBR_RST_CFG = 16'h0600;
   localparam logic [15:0] CBR_RST_CH0 = 16'h0000;
   // identification: channel count field plus arbitrary low/high bits
   localparam logic [3:0] CBR_ID_CHANCNT = 4'h3;
   localparam logic [3:0] CBR_ID_TOP = 4'h2;
   localparam logic [7:0] CBR_ID_REV = 8'h5A; // arbitrary value

   // ==================================================
   // field positions
   localparam int CBR_MODE_FMT_BIT = 0;
   localparam int CBR_CLOCK_EN_LSB = 8;
   localparam int CBR_STATUS_FLAG_LSB = 0;

   // ==================================================
   // timing: length of the low pulse in pulse format
   localparam int CBR_PULSE_NS = 40;
   localparam int CBR_CLK_NS = 10;
   localparam int CBR_PULSE_CYC = (CBR_PULSE_NS + CBR_CLK_NS - 1) / CBR_CLK_NS;

   typedef enum logic {CBR_SEQ_IDLE, CBR_SEQ_SEND} cbr_seq_type;
endpackage

/* File: hw/cbr_chan_if.sv */
`timescale 1ns/1ps
interface cbr_chan_if #(
   parameter int DATA_W = 24
);
   logic conv_done;
   logic [DATA_W-1:0] conv_data;
   logic rd_done;
   logic clear;
   logic [DATA_W-1:0] fifo_data;
   logic ready_flag;
   logic loaded;
   logic moved;

   modport chan (
      input conv_done, conv_data, rd_done, clear,
      output fifo_data, ready_flag, loaded, moved
   );
   modport ctrl (
      output conv_done, conv_data, rd_done, clear,
      input fifo_data, ready_flag, loaded, moved
   );
endinterface

/* File: hw/cbr_chan.sv */
`timescale 1ns/1ps
module cbr_chan #(
   parameter int DATA_W = 24
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // channel link
   cbr_chan_if.chan ch
);
   typedef struct packed {
      logic [DATA_W-1:0] obuf;
      logic [DATA_W-1:0] fifo;
      logic unread;
      logic pend;
      logic loaded;
      logic moved;
   } cbr_chan_type;

   cbr_chan_type q, d;

   // ==================================================
   // buffer update; the read is applied before a conversion in the same cycle
   always_comb begin
      d = q;
      d.loaded = 1'b0;
      d.moved = 1'b0;
      if (ch.rd_done) begin
         d.unread = 1'b0;
         if (q.pend) begin
            d.fifo = q.obuf;
            d.pend = 1'b0;
            d.unread = 1'b1;
            d.moved = 1'b1;
         end
      end
      if (ch.conv_done) begin
         d.obuf = ch.conv_data;
         if (!d.unread) begin
            d.fifo = ch.conv_data;
            d.unread = 1'b1;
            d.loaded = 1'b1;
         end else if (d.pend) begin
            d.fifo = ch.conv_data;
            d.pend = 1'b0;
            d.loaded = 1'b1;
         end else begin
            d.pend = 1'b1;
         end
      end
      if (ch.clear) begin
         d = '0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ch.fifo_data = q.fifo;
   assign ch.ready_flag = q.unread;
   assign ch.loaded = q.loaded;
   assign ch.moved = q.moved;
endmodule

/* File: hw/cbr_ready.sv */
`timescale 1ns/1ps
module cbr_ready
   import cbr_pkg::*;
#(
   parameter int PULSE_CYC = CBR_PULSE_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // events
   input wire logic fmt_pulse_i,
   input wire logic loaded_i,
   input wire logic moved_i,
   input wire logic rd_done_i,
   input wire logic clear_i,
   // pin
   output logic data_ready_n_o
);
   typedef struct packed {
      logic pin_n;
      logic relow;
      logic [7:0] cnt;
   } cbr_ready_type;

   cbr_ready_type q, d;

   // ==================================================
   always_comb begin
      d = q;
      d.relow = 1'b0;
      if (fmt_pulse_i) begin
         // skipped pulses follow from loaded_i only firing on a real queue load
         if (loaded_i) begin
            d.pin_n = 1'b0;
            d.cnt = 8'(PULSE_CYC - 1);
         end else if (q.cnt != 8'h00) begin
            d.cnt = q.cnt - 8'h01;
         end else begin
            d.pin_n = 1'b1;
         end
      end else begin
         d.cnt = 8'h00;
         if (q.relow) begin
            d.pin_n = 1'b0;
         end
         if (rd_done_i) begin
            d.pin_n = 1'b1;
            d.relow = moved_i;
         end else if (loaded_i || moved_i) begin
            // one high cycle first, so a falling edge is always seen
            d.pin_n = 1'b1;
            d.relow = 1'b1;
         end
      end
      if (clear_i) begin
         d.pin_n = 1'b1;
         d.relow = 1'b0;
         d.cnt = 8'h00;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{pin_n: 1'b1, relow: 1'b0, cnt: 8'h00};
      end else begin
         q <= d;
      end
   end

   assign data_ready_n_o = q.pin_n;
endmodule

/* File: hw/cbr_top.sv */
`timescale 1ns/1ps
// How it works
// - empty or read queue: load both stages
// - unread queue, nothing pending: only output buffer updates
// - after read, pending result moves into queue
// - repeat read resends queue, buffers unchanged
// - conversion after read loads both stages if nothing was pending
// - second unread conversion overwrites both stages
// - level format: low on data, high when read
// - pulse format: short low pulse per result
// - level, unread: stays low, brief high
// - pulse, unread: next pulse skipped
// - data read clears status ready flags of channels with nothing pending
// - sync strobe clears both buffer stages
// - level double-read: narrow high pulse
// - serial data comes only from queue
// - each stage holds one result
module cbr_top
   import cbr_pkg::*;
#(
   parameter int NCH = CBR_CHAN_CNT,
   parameter int DATA_W = CBR_DATA_W,
   parameter int PULSE_CYC = CBR_PULSE_CYC,
   parameter logic [7:0] ID_REV = CBR_ID_REV
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // conversion side
   input wire logic [NCH-1:0] conv_done_i,
   input wire logic [NCH-1:0][DATA_W-1:0] conv_data_i,
   input wire logic sync_pulse_i,
   // data read side
   input wire logic frame_rd_i,
   input wire logic out_ready_i,
   output logic out_valid_o,
   output logic [DATA_W-1:0] out_data_o,
   output logic [1:0] out_chan_o,
   // register port
   input wire logic [CBR_ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [CBR_REG_W-1:0] reg_wdata_i,
   output logic [CBR_REG_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // ready pin
   output logic data_ready_n_o
);
   typedef struct packed {
      cbr_seq_type st;
      logic [1:0] idx;
      logic [1:0] cnt;
      logic [DATA_W-1:0] dat0;
      logic [DATA_W-1:0] dat1;
      logic [1:0] chn0;
      logic [1:0] chn1;
      logic [15:0] mode;
      logic [15:0] clk;
      logic [15:0] gain;
      logic [15:0] cfg;
      logic [15:0] channel0_phase_input_config;
      logic [15:0] ocal_hi;
      logic [15:0] ocal_lo;
      logic [15:0] rdata;
      logic rvalid;
   } cbr_top_type;

   cbr_top_type q, d;

   logic [NCH-1:0][DATA_W-1:0] fifo_data;
   logic [NCH-1:0] ready_flag;
   logic [NCH-1:0] loaded;
   logic [NCH-1:0] moved;
   logic [NCH-1:0] chan_en;
   logic rd_done;
   logic pop;
   logic push;
   logic [1:0] slot;

   // ==================================================
   // channel stage pairs
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      cbr_chan_if #(.DATA_W(DATA_W)) link ();
      assign link.conv_done = conv_done_i[i];
      assign link.conv_data = conv_data_i[i];
      assign link.rd_done = rd_done;
      assign link.clear = sync_pulse_i;
      assign fifo_data[i] = link.fifo_data;
      assign ready_flag[i] = link.ready_flag;
      assign loaded[i] = link.loaded;
      assign moved[i] = link.moved;
      cbr_chan #(.DATA_W(DATA_W)) u_chan (
         .sys_clk_i(sys_clk_i),
         .rst_i(rst_i),
         .ch(link)
      );
   end

   assign chan_en = q.clk[CBR_CLOCK_EN_LSB +: NCH];

   // ==================================================
   // register read decode
   function automatic logic [15:0] reg_read(input logic [CBR_ADDR_W-1:0] a,
                                            input cbr_top_type s,
                                            input logic [NCH-1:0] flags);
      logic [15:0] v;
      v = 16'h0000;
      unique case (a)
         CBR_OFS_IDENT: v = {CBR_ID_TOP, CBR_ID_CHANCNT, ID_REV};
         CBR_OFS_STATUS: begin
            v = CBR_RST_STATUS;
            v[CBR_STATUS_FLAG_LSB +: NCH] = flags;
         end
         CBR_OFS_MODE: v = s.mode;
         CBR_OFS_CLOCK: v = s.clk;
         CBR_OFS_GAIN: v = s.gain;
         CBR_OFS_CFG: v = s.cfg;
         CBR_OFS_CHANNEL0_PHASE_INPUT_CONFIG: v = s.channel0_phase_input_config;
         CBR_OFS_CH0_OCAL_HI: v = s.ocal_hi;
         CBR_OFS_CH0_OCAL_LO: v = s.ocal_lo;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // ==================================================
   // read sequencer and two-entry output buffer
   always_comb begin
      d = q;
      d.rvalid = 1'b0;
      rd_done = 1'b0;
      push = 1'b0;
      pop = (q.cnt != 2'd0) && out_ready_i;
      slot = pop ? q.cnt - 2'd1 : q.cnt;
      if (pop) begin
         d.dat0 = q.dat1;
         d.chn0 = q.chn1;
      end
      unique case (q.st)
         CBR_SEQ_IDLE: begin
            if (frame_rd_i) begin
               d.st = CBR_SEQ_SEND;
               d.idx = 2'd0;
            end
         end
         CBR_SEQ_SEND: begin
            // a full buffer holds the sequencer, so a stalled receiver loses nothing
            push = chan_en[q.idx] && ((q.cnt != 2'd2) || pop);
            if (!chan_en[q.idx] || push) begin
               if (q.idx == 2'(NCH - 1)) begin
                  d.st = CBR_SEQ_IDLE;
                  rd_done = 1'b1;
               end else begin
                  d.idx = q.idx + 2'd1;
               end
            end
         end
      endcase
      if (push) begin
         if (slot == 2'd0) begin
            d.dat0 = fifo_data[q.idx];
            d.chn0 = q.idx;
         end else begin
            d.dat1 = fifo_data[q.idx];
            d.chn1 = q.idx;
         end
      end
      d.cnt = slot + (push ? 2'd1 : 2'd0);
      if (sync_pulse_i) begin
         d.st = CBR_SEQ_IDLE;
         d.cnt = 2'd0;
         rd_done = 1'b0;
      end
      // writes to read-only or unmapped offsets fall through unchanged
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            CBR_OFS_MODE: d.mode = reg_wdata_i;
            CBR_OFS_CLOCK: d.clk = reg_wdata_i;
            CBR_OFS_GAIN: d.gain = reg_wdata_i;
            CBR_OFS_CFG: d.cfg = reg_wdata_i;
            CBR_OFS_CHANNEL0_PHASE_INPUT_CONFIG: d.channel0_phase_input_config = reg_wdata_i;
            CBR_OFS_CH0_OCAL_HI: d.ocal_hi = reg_wdata_i;
            CBR_OFS_CH0_OCAL_LO: d.ocal_lo = reg_wdata_i;
            default: d.mode = q.mode;
         endcase
      end
      if (reg_rd_i) begin
         d.rdata = reg_read(reg_addr_i, q, ready_flag);
         d.rvalid = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.mode <= CBR_RST_MODE;
         q.clk <= CBR_RST_CLOCK;
         q.gain <= CBR_RST_GAIN;
         q.cfg <= CBR_RST_CFG;
         q.channel0_phase_input_config <= CBR_RST_CH0;
         q.ocal_hi <= CBR_RST_CH0;
         q.ocal_lo <= CBR_RST_CH0;
      end else begin
         q <= d;
      end
   end

   assign out_valid_o = (q.cnt != 2'd0);
   assign out_data_o = q.dat0;
   assign out_chan_o = q.chn0;
   assign reg_rdata_o = q.rdata;
   assign reg_rvalid_o = q.rvalid;

   // ==================================================
   // ready pin
   cbr_ready #(.PULSE_CYC(PULSE_CYC)) u_ready (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .fmt_pulse_i(q.mode[CBR_MODE_FMT_BIT]),
      .loaded_i(|(loaded & chan_en)),
      .moved_i(|(moved & chan_en)),
      .rd_done_i(rd_done),
      .clear_i(sync_pulse_i),
      .data_ready_n_o(data_ready_n_o)
   );
endmodule

/* File: bench/cbr_top_sva.sv */
`timescale 1ns/1ps
module cbr_top_sva
   import cbr_pkg::*;
#(
   parameter int NCH = CBR_CHAN_CNT,
   parameter int DATA_W = CBR_DATA_W
) (
   // clock and reset
   input logic sys_clk_i,
   input logic rst_i,
   // conversion and read side
   input logic [NCH-1:0] conv_done_i,
   input logic sync_pulse_i,
   input logic frame_rd_i,
   input logic out_ready_i,
   input logic out_valid_o,
   input logic [DATA_W-1:0] out_data_o,
   input logic [1:0] out_chan_o,
   // register port and pin
   input logic [CBR_ADDR_W-1:0] reg_addr_i,
   input logic reg_wr_i,
   input logic reg_rd_i,
   input logic [CBR_REG_W-1:0] reg_wdata_i,
   input logic [CBR_REG_W-1:0] reg_rdata_o,
   input logic data_ready_n_o
);
   // ==========
   // format shadow: the mode bit is only visible as register writes
   logic fmt_q;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fmt_q <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == CBR_OFS_MODE) begin
         fmt_q <= reg_wdata_i[CBR_MODE_FMT_BIT];
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   // assertions; pulse width below holds for a pulse length of 4 (the bench's choice)
   // a queue load reaches the pin three edges later: channel flop, then one high cycle
   a_unmapped_zero: assert property (
      reg_rd_i && reg_addr_i == 6'h05 |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_frame_answer: assert property (
      frame_rd_i && !out_valid_o && !sync_pulse_i |-> ##2 out_valid_o)
      else $error("frame word late");
   a_chan_order: assert property (
      out_valid_o && out_ready_i && out_chan_o == 2'h0 && !sync_pulse_i
      |=> out_valid_o && out_chan_o == 2'h1)
      else $error("channel order broken");
   a_out_hold: assert property (
      out_valid_o && !out_ready_i && !sync_pulse_i |=> out_valid_o && $stable(out_data_o))
      else $error("stalled word lost");
   a_sync_clear: assert property (
      sync_pulse_i |-> ##[1:2] (data_ready_n_o && !out_valid_o))
      else $error("sync did not clear");
   a_level_fall: assert property (
      !fmt_q && (|conv_done_i) && data_ready_n_o && !sync_pulse_i && !frame_rd_i
      |-> ##[1:3] !data_ready_n_o)
      else $error("level pin not low");
   a_level_rise: assert property (
      !fmt_q && frame_rd_i && !out_valid_o |-> ##[1:20] data_ready_n_o)
      else $error("level pin not raised");
   a_pulse_width: assert property (
      fmt_q && $fell(data_ready_n_o) |-> !data_ready_n_o [*4] ##1 data_ready_n_o)
      else $error("pulse width wrong");
   c_sync: cover property (sync_pulse_i);
   c_pulse: cover property (fmt_q && $fell(data_ready_n_o));
   c_stall: cover property (out_valid_o && !out_ready_i);
endmodule
bind cbr_top cbr_top_sva #(.NCH(NCH), .DATA_W(DATA_W)) sva_u (.sys_clk_i, .rst_i,
   .conv_done_i, .sync_pulse_i, .frame_rd_i, .out_ready_i, .out_valid_o, .out_data_o,
   .out_chan_o, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
   .data_ready_n_o);

/* File: bench/cbr_host.sv */
`timescale 1ns/1ps
module cbr_host
   import cbr_pkg::*;
(
   // clock and reset
   input logic sys_clk_i,
   input logic rst_i,
   // word stream
   input logic out_valid_i,
   input logic [CBR_DATA_W-1:0] out_data_i,
   input logic [1:0] out_chan_i,
   input logic stall_i,
   output logic out_ready_o
);
   // received words, channel tag above data
   logic [25:0] q[$];
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_ready_o <= 1'b0;
      end else begin
         if (out_valid_i && out_ready_o) begin
            q.push_back({out_chan_i, out_data_i});
         end
         // takes every word at once unless told to stall
         out_ready_o <= !stall_i;
      end
   end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
   $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import cbr_pkg::*;
   // ==========
   // signals
   logic sys_clk_i, rst_i, sync_pulse_i, frame_rd_i, out_ready_i, out_valid_o, stall;
   logic [2:0] conv_done_i;
   logic [2:0][23:0] conv_data_i;
   logic [23:0] out_data_o;
   logic [1:0] out_chan_o;
   logic [5:0] reg_addr_i;
   logic reg_wr_i, reg_rd_i, reg_rvalid_o, data_ready_n_o, seen_hi, prev;
   logic [15:0] reg_wdata_i, reg_rdata_o;
   int err_total, total_checks, lows, falls;
   logic [5:0] ra [9] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h09, 6'h0A, 6'h0B, 6'h05};
   logic [15:0] rv [9] = '{16'h0540, 16'h0510, 16'h070E, 16'h0000, 16'h0600, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};
   cbr_top #(.PULSE_CYC(4)) dut_u (.sys_clk_i, .rst_i, .conv_done_i, .conv_data_i,
      .sync_pulse_i, .frame_rd_i, .out_ready_i, .out_valid_o, .out_data_o, .out_chan_o,
      .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
      .data_ready_n_o);
   cbr_host host_u (.sys_clk_i, .rst_i, .out_valid_i(out_valid_o), .out_data_i(out_data_o),
      .out_chan_i(out_chan_o), .stall_i(stall), .out_ready_o(out_ready_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      if (data_ready_n_o === 1'b1) begin
         seen_hi <= 1'b1;
      end
   end
   // ==========
   // tasks
   function automatic logic [23:0] val(input int n, input int c);
      return 24'(n * 16 + c);
   endfunction
   task automatic wreg(input logic [5:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rreg(input logic [5:0] a, input logic [15:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      `CHK(reg_rvalid_o, 1'b1)
      `CHK(reg_rdata_o, e)
   endtask
   // counts falls and low samples of the pin after one result on all channels
   task automatic conv(input int n);
      @(posedge sys_clk_i);
      prev = data_ready_n_o;
      conv_done_i <= 3'h7;
      for (int c = 0; c < 3; c++) conv_data_i[c] <= val(n, c);
      @(posedge sys_clk_i);
      conv_done_i <= 3'h0;
      lows = 0;
      falls = 0;
      repeat (10) begin
         @(posedge sys_clk_i);
         #1;
         if (data_ready_n_o === 1'b0) lows++;
         if (prev === 1'b1 && data_ready_n_o === 1'b0) falls++;
         prev = data_ready_n_o;
      end
   endtask
   task automatic rd_frame(input int n, input logic st);
      host_u.q.delete();
      seen_hi = 1'b0;
      @(posedge sys_clk_i);
      frame_rd_i <= 1'b1;
      stall <= st;
      @(posedge sys_clk_i);
      frame_rd_i <= 1'b0;
      if (st) begin
         repeat (12) @(posedge sys_clk_i);
         stall <= 1'b0;
      end
      repeat (40) if (host_u.q.size() < 3) @(posedge sys_clk_i);
      repeat (3) @(posedge sys_clk_i);
      #1;
      `CHK(host_u.q.size(), 3)
      for (int c = 0; c < 3; c++) `CHK(host_u.q[c], {2'(c), val(n, c)})
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========
   // sequence
   initial begin
      #100us;
      err_total++;
      summarize();
   end
   initial begin
      {rst_i, seen_hi} = 2'b10;
      {conv_done_i, conv_data_i, sync_pulse_i, frame_rd_i, stall} = '0;
      {reg_addr_i, reg_wr_i, reg_rd_i, reg_wdata_i} = '0;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      foreach (ra[i]) rreg(ra[i], rv[i]);
      rreg(CBR_OFS_IDENT, {8'h23, CBR_ID_REV});
      wreg(6'h01, 16'hFFFF);
      rreg(6'h01, 16'h0540);
      wreg(6'h05, 16'hFFFF);
      rreg(6'h05, 16'h0000);
      wreg(6'h04, 16'h0123);
      rreg(6'h04, 16'h0123);
      conv(1);
      `CHK(falls, 1)
      rreg(6'h01, 16'h0547);
      rd_frame(1, 1'b0);
      rreg(6'h01, 16'h0540);
      `CHK(data_ready_n_o, 1'b1)
      rd_frame(1, 1'b0);
      conv(2);
      `CHK(falls, 1)
      conv(3);
      `CHK(falls, 0)
      `CHK(lows, 10)
      rd_frame(2, 1'b0);
      `CHK(seen_hi, 1'b1)
      `CHK(data_ready_n_o, 1'b0)
      rd_frame(3, 1'b0);
      rd_frame(3, 1'b0);
      conv(4);
      conv(5);
      conv(6);
      `CHK(falls, 1)
      rd_frame(6, 1'b1);
      conv(7);
      @(posedge sys_clk_i);
      sync_pulse_i <= 1'b1;
      @(posedge sys_clk_i);
      sync_pulse_i <= 1'b0;
      rreg(6'h01, 16'h0540);
      conv(8);
      rd_frame(8, 1'b0);
      wreg(CBR_OFS_MODE, 16'h0511);
      conv(10);
      `CHK(lows, 4)
      conv(11);
      `CHK(falls, 0)
      conv(12);
      `CHK(lows, 4)
      rd_frame(12, 1'b0);
      wreg(CBR_OFS_MODE, 16'h0510);
      summarize();
   end
endmodule
